// ---- rtl/dsdac_decoder.sv ----
// dual converter serial command decoder, register file and load control
`timescale 1ns/100ps

module dsdac_decoder #(
    parameter bit HAS_LOAD_STROBE = 1'b1,
    parameter int DATA_W = dsdac_pkg::DATA_W
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdata,
    input wire logic i_load_strobe_n,
    output logic [DATA_W-1:0] o_input_a,
    output logic [DATA_W-1:0] o_input_b,
    output logic [DATA_W-1:0] o_conv_a,
    output logic [DATA_W-1:0] o_conv_b,
    output logic o_power_down_a,
    output logic o_power_down_b,
    output logic o_update_pending,
    output logic o_command_strobe
);

    // ------------------------------------------------------------
    // link side
    // ------------------------------------------------------------
    dsdac_word_if word_bus ();

    dsdac_shift u_shift (
        .i_sclk(i_sclk),
        .i_rst_b(i_rst_b),
        .i_cs_n(i_cs_n),
        .i_sdata(i_sdata),
        .word_bus(word_bus.producer)
    );

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [dsdac_pkg::SYNC_STAGES-1:0] cs_sync_q;
    logic [dsdac_pkg::SYNC_STAGES-1:0] cs_sync_d;
    logic [dsdac_pkg::SYNC_STAGES-1:0] ls_sync_q;
    logic [dsdac_pkg::SYNC_STAGES-1:0] ls_sync_d;
    logic cs_last_q;
    logic cs_last_d;
    logic ls_last_q;
    logic ls_last_d;
    logic cs_level;
    logic ls_level;
    logic cs_rise;
    logic ls_fall;

    always_comb begin
        cs_sync_d = {cs_sync_q[0], i_cs_n};
        ls_sync_d = {ls_sync_q[0], i_load_strobe_n};
        cs_last_d = cs_sync_q[1];
        ls_last_d = ls_sync_q[1];
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_sync_q <= 2'h3;
            ls_sync_q <= 2'h3;
            cs_last_q <= 1'b1;
            ls_last_q <= 1'b1;
        end else begin
            cs_sync_q <= cs_sync_d;
            ls_sync_q <= ls_sync_d;
            cs_last_q <= cs_last_d;
            ls_last_q <= ls_last_d;
        end
    end

    assign cs_level = cs_sync_q[1];
    assign ls_level = ls_sync_q[1];
    assign cs_rise = cs_level && !cs_last_q;
    assign ls_fall = HAS_LOAD_STROBE && !ls_level && ls_last_q;

    // ------------------------------------------------------------
    // command fields
    // ------------------------------------------------------------
    // unused bits 15..13 are never looked at
    logic [dsdac_pkg::WORD_W-1:0] word;
    logic power_down_bit;
    logic load_enable_bit;
    logic load_timing_bit;
    logic channel_b_select;
    logic channel_a_select;
    logic [DATA_W-1:0] data_byte;
    logic [dsdac_pkg::CHAN_N-1:0] chan_sel;
    logic strobe_low_at_cmd;

    // word is stable: serial clock has stopped once select is high
    assign word = word_bus.word;
    assign power_down_bit = word[dsdac_pkg::POWER_DOWN_POS];
    assign load_enable_bit = word[dsdac_pkg::LOAD_ENABLE_POS];
    assign load_timing_bit = word[dsdac_pkg::LOAD_TIMING_POS];
    assign channel_b_select = word[dsdac_pkg::CHANNEL_B_POS];
    assign channel_a_select = word[dsdac_pkg::CHANNEL_A_POS];
    assign data_byte = word[dsdac_pkg::DATA_MSB_POS:dsdac_pkg::DATA_LSB_POS];
    assign chan_sel = {channel_b_select, channel_a_select};
    assign strobe_low_at_cmd = !ls_level;

    // defer only when a strobe exists and the timing bit asks for it
    function automatic logic cmd_defers(input logic timing,
                                        input logic strobe_low);
        cmd_defers = HAS_LOAD_STROBE && timing && !strobe_low;
    endfunction : cmd_defers

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic do_load;
    logic do_update_now;
    logic do_arm;
    logic do_power;

    always_comb begin
        do_load = 1'b0;
        do_update_now = 1'b0;
        do_arm = 1'b0;
        do_power = 1'b0;
        if (cs_rise) begin
            if (chan_sel == 2'h0) begin
                // update-only: no data, inputs untouched
                if (load_enable_bit
                        && (!power_down_bit || !HAS_LOAD_STROBE)) begin
                    if (cmd_defers(load_timing_bit, strobe_low_at_cmd)) begin
                        do_arm = 1'b1;
                    end else begin
                        do_update_now = 1'b1;
                    end
                end
            end else begin
                do_load = 1'b1;
                do_power = 1'b1;
                if (load_enable_bit) begin
                    if (cmd_defers(load_timing_bit, strobe_low_at_cmd)) begin
                        do_arm = 1'b1;
                    end else begin
                        do_update_now = 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // deferred update tracker
    // ------------------------------------------------------------
    dsdac_pkg::dsdac_state_t state_q;
    dsdac_pkg::dsdac_state_t state_d;
    logic do_update_late;

    always_comb begin
        state_d = state_q;
        do_update_late = 1'b0;
        case (state_q)
            dsdac_pkg::DSDAC_IDLE: begin
                if (do_arm) begin
                    state_d = dsdac_pkg::DSDAC_ARMED;
                end
            end
            dsdac_pkg::DSDAC_ARMED: begin
                if (cs_rise) begin
                    // a newer command replaces the waiting one
                    state_d = do_arm ? dsdac_pkg::DSDAC_ARMED
                                     : dsdac_pkg::DSDAC_IDLE;
                end else if (ls_fall) begin
                    do_update_late = 1'b1;
                    state_d = dsdac_pkg::DSDAC_IDLE;
                end
            end
            default: begin
                state_d = dsdac_pkg::DSDAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= dsdac_pkg::DSDAC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // per-channel input, converter and power registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] in_q [dsdac_pkg::CHAN_N];
    logic [DATA_W-1:0] in_d [dsdac_pkg::CHAN_N];
    logic [DATA_W-1:0] conv_q [dsdac_pkg::CHAN_N];
    logic [DATA_W-1:0] conv_d [dsdac_pkg::CHAN_N];
    logic [dsdac_pkg::CHAN_N-1:0] pd_q;
    logic [dsdac_pkg::CHAN_N-1:0] pd_d;

    generate
        for (genvar ch = 0; ch < dsdac_pkg::CHAN_N; ch++) begin : g_chan
            always_comb begin
                in_d[ch] = in_q[ch];
                conv_d[ch] = conv_q[ch];
                pd_d[ch] = pd_q[ch];
                if (do_load && chan_sel[ch]) begin
                    in_d[ch] = data_byte;
                end
                if (do_power && chan_sel[ch]) begin
                    pd_d[ch] = power_down_bit;
                end
                if (do_update_now || do_update_late) begin
                    // both converters take the freshly loaded inputs
                    conv_d[ch] = in_d[ch];
                end
            end

            always_ff @(posedge i_clock or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    in_q[ch] <= dsdac_pkg::DATA_RESET;
                    conv_q[ch] <= dsdac_pkg::DATA_RESET;
                    pd_q[ch] <= 1'b0;
                end else begin
                    in_q[ch] <= in_d[ch];
                    conv_q[ch] <= conv_d[ch];
                    pd_q[ch] <= pd_d[ch];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // command strobe
    // ------------------------------------------------------------
    logic cmd_seen_q;
    logic cmd_seen_d;

    always_comb begin
        cmd_seen_d = cs_rise;
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd_seen_q <= 1'b0;
        end else begin
            cmd_seen_q <= cmd_seen_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_input_a = in_q[0];
    assign o_input_b = in_q[1];
    assign o_conv_a = conv_q[0];
    assign o_conv_b = conv_q[1];
    assign o_power_down_a = pd_q[0];
    assign o_power_down_b = pd_q[1];
    assign o_update_pending = (state_q == dsdac_pkg::DSDAC_ARMED);
    assign o_command_strobe = cmd_seen_q;

endmodule : dsdac_decoder

// ---- rtl/dsdac_pkg.sv ----
// shared constants and types for the dual converter command decoder
package dsdac_pkg;

    // ------------------------------------------------------------
    // command word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int DATA_W = 8;
    localparam int CHAN_N = 2;
    localparam int POWER_DOWN_POS = 12;
    localparam int LOAD_ENABLE_POS = 11;
    localparam int LOAD_TIMING_POS = 10;
    localparam int CHANNEL_B_POS = 9;
    localparam int CHANNEL_A_POS = 8;
    localparam int DATA_MSB_POS = 7;
    localparam int DATA_LSB_POS = 0;

    // ------------------------------------------------------------
    // reset values and crossing depth
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // deferred-update tracker
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DSDAC_IDLE = 2'b01,
        DSDAC_ARMED = 2'b10
    } dsdac_state_t;

endpackage : dsdac_pkg

// ---- rtl/dsdac_word_if.sv ----
// carrier for the captured serial word between link and decoder
`timescale 1ns/100ps
interface dsdac_word_if;
    logic [dsdac_pkg::WORD_W-1:0] word;

    modport producer (output word);
    modport consumer (input word);
endinterface : dsdac_word_if

// ---- rtl/dsdac_shift.sv ----
// serial-clock domain input shift register
`timescale 1ns/100ps
module dsdac_shift (
    input wire logic i_sclk,
    input wire logic i_rst_b,
    input wire logic i_cs_n,
    input wire logic i_sdata,
    dsdac_word_if.producer word_bus
);

    // ------------------------------------------------------------
    // shift register, msb first
    // ------------------------------------------------------------
    logic [dsdac_pkg::WORD_W-1:0] shift_q;
    logic [dsdac_pkg::WORD_W-1:0] shift_d;

    always_comb begin
        shift_d = shift_q;
        if (!i_cs_n) begin
            shift_d = {shift_q[dsdac_pkg::WORD_W-2:0], i_sdata};
        end
    end

    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shift_q <= dsdac_pkg::WORD_RESET;
        end else begin
            shift_q <= shift_d;
        end
    end

    // held still once the frame ends, since the clock stops
    assign word_bus.word = shift_q;

endmodule : dsdac_shift

// ---- tb/dsdac_decoder_sva.sv ----
// port-level assertions for the dual converter command decoder
`timescale 1ns/100ps
module dsdac_decoder_sva #(
    parameter bit HAS_LOAD_STROBE = 1'b1,
    parameter int DATA_W = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdata,
    input wire logic i_load_strobe_n,
    input wire logic [DATA_W-1:0] o_input_a,
    input wire logic [DATA_W-1:0] o_input_b,
    input wire logic [DATA_W-1:0] o_conv_a,
    input wire logic [DATA_W-1:0] o_conv_b,
    input wire logic o_power_down_a,
    input wire logic o_power_down_b,
    input wire logic o_update_pending,
    input wire logic o_command_strobe
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    a_reset_clears_all: assert property (
        $rose(i_rst_b) |-> !(|{o_input_a, o_input_b, o_conv_a, o_conv_b,
        o_power_down_a, o_power_down_b, o_update_pending}))
        else $error("outputs not clear after reset");
    a_strobe_one_cycle: assert property (
        o_command_strobe |=> !o_command_strobe)
        else $error("command pulse longer than one cycle");
    a_exec_after_cs: assert property (
        o_command_strobe |-> i_cs_n && (!$past(i_cs_n, 4) ||
        !$past(i_cs_n, 5) || !$past(i_cs_n, 6) || !$past(i_cs_n, 7)))
        else $error("command executed without a chip select rise");
    a_input_by_cmd: assert property (
        $changed({o_input_a, o_input_b}) |-> o_command_strobe)
        else $error("input register changed outside a command");
    a_power_by_cmd: assert property (
        $changed({o_power_down_a, o_power_down_b}) |-> o_command_strobe)
        else $error("power state changed outside a command");
    a_conv_cause: assert property (
        $changed({o_conv_a, o_conv_b}) |->
        $fell(o_update_pending) || o_command_strobe)
        else $error("converter register changed without cause");
    a_pend_arm: assert property (
        $rose(o_update_pending) |-> o_command_strobe)
        else $error("pending update armed outside a command");
    a_pend_resolve: assert property (
        HAS_LOAD_STROBE && o_update_pending && $fell(i_load_strobe_n)
        |-> ##[1:6] !o_update_pending)
        else $error("strobe fall did not resolve pending update");
    a_pend_copies: assert property (
        $fell(o_update_pending) |-> (o_conv_a == o_input_a &&
        o_conv_b == o_input_b) || o_command_strobe)
        else $error("deferred update did not copy input registers");
    a_no_strobe_idle: assert property (
        !HAS_LOAD_STROBE |-> !o_update_pending)
        else $error("pending update without a load strobe");
endmodule : dsdac_decoder_sva

bind dsdac_decoder dsdac_decoder_sva #(
    .HAS_LOAD_STROBE(HAS_LOAD_STROBE), .DATA_W(DATA_W)
) sva_u (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_sclk(i_sclk),
    .i_cs_n(i_cs_n), .i_sdata(i_sdata), .i_load_strobe_n(i_load_strobe_n),
    .o_input_a(o_input_a), .o_input_b(o_input_b), .o_conv_a(o_conv_a),
    .o_conv_b(o_conv_b), .o_power_down_a(o_power_down_a),
    .o_power_down_b(o_power_down_b), .o_update_pending(o_update_pending),
    .o_command_strobe(o_command_strobe)
);

// ---- tb/dsdac_host_model.sv ----
// serial host controller driving the link and the load strobe
`timescale 1ns/100ps
module dsdac_host_model (
    input wire logic i_clock,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdata,
    output logic o_load_strobe_n
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdata = 1'b0;
        o_load_strobe_n = 1'b1;
    end

    task automatic send(input logic [15:0] w);
        @(negedge i_clock);
        #3 o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_sdata = w[i]; // unused bits first, data lsb last
            #16 o_sclk = 1'b1; // bit settled before the rise
            #16 o_sclk = 1'b0;
        end
        #7 o_cs_n = 1'b1; // clock stopped before execute edge
        o_sdata = ~o_sdata;
    endtask : send

    task automatic strobe(input logic v);
        @(negedge i_clock);
        o_load_strobe_n = v; // level held over execute
    endtask : strobe
endmodule : dsdac_host_model

// ---- tb/tb_top.sv ----
// self-checking bench for the dual converter command decoder
`timescale 1ns/100ps
module tb_top;
    logic i_clock = 1'b0;
    logic i_rst_b;
    logic sclk, cs_n, sdata, strobe_n, pd_a, pd_b, pend, cmd_stb;
    logic [7:0] in_a, in_b, cv_a, cv_b;
    logic [7:0] ia = 8'h00, ib = 8'h00, ca = 8'h00, cb = 8'h00;
    logic pa = 1'h0, pb = 1'h0, ep = 1'h0;
    // strobeless variant on the same link
    logic n_pd_a, n_pd_b, n_pend, n_stb;
    logic [7:0] n_in_a, n_in_b, n_cv_a, n_cv_b;
    logic [7:0] na = 8'h00, nb = 8'h00, nca = 8'h00, ncb = 8'h00;
    logic npa = 1'h0, npb = 1'h0;
    int fails = 0;
    int checked = 0;
    logic [16:0] plan [14] = '{
        17'h0e15a, // load a with unused bits set
        17'h002a5, // load b only
        17'h008ff, // update only
        17'h00981, // load a and update
        17'h00e17, // strobe low, immediate
        17'h10f42, // strobe high, deferred
        17'h01133, // power down a
        17'h01a66, // power down b, update
        17'h01f99, // power down both, strobe low
        17'h11dc3, // power down a, deferred
        17'h010ee, // power down, no address
        17'h004ee, // no address, no load
        17'h10c00, // deferred, no address
        17'h00177}; // power a back up

    always #10 i_clock = ~i_clock;

    dsdac_host_model host_u (.i_clock(i_clock), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_sdata(sdata), .o_load_strobe_n(strobe_n));
    dsdac_decoder dut_u (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_sdata(sdata),
        .i_load_strobe_n(strobe_n), .o_input_a(in_a), .o_input_b(in_b),
        .o_conv_a(cv_a), .o_conv_b(cv_b), .o_power_down_a(pd_a),
        .o_power_down_b(pd_b), .o_update_pending(pend),
        .o_command_strobe(cmd_stb));
    dsdac_decoder #(.HAS_LOAD_STROBE(1'b0), .DATA_W(8)) dut_nl_u (
        .i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_sdata(sdata),
        .i_load_strobe_n(strobe_n), .o_input_a(n_in_a), .o_input_b(n_in_b),
        .o_conv_a(n_cv_a), .o_conv_b(n_cv_b), .o_power_down_a(n_pd_a),
        .o_power_down_b(n_pd_b), .o_update_pending(n_pend),
        .o_command_strobe(n_stb));

    task automatic chk(input string n, input logic [7:0] s, e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic chk_all();
        chk("input_a", in_a, ia);
        chk("input_b", in_b, ib);
        chk("conv_a", cv_a, ca);
        chk("conv_b", cv_b, cb);
        chk("power_down", {6'h00, pd_b, pd_a}, {6'h00, pb, pa});
        chk("pending", {7'h00, pend}, {7'h00, ep});
        chk("nl_input_a", n_in_a, na);
        chk("nl_input_b", n_in_b, nb);
        chk("nl_conv_a", n_cv_a, nca);
        chk("nl_conv_b", n_cv_b, ncb);
        chk("nl_pd", {6'h00, n_pd_b, n_pd_a}, {6'h00, npb, npa});
        chk("nl_pending", {7'h00, n_pend}, 8'h00);
    endtask : chk_all

    task automatic cmd(input logic [16:0] e);
        logic up;
        logic seen;
        up = e[11];
        ep = 1'b0;
        seen = 1'b0;
        if (e[9:8] != 2'h0) begin
            if (e[8]) begin
                ia = e[7:0];
                pa = e[12];
                na = e[7:0];
                npa = e[12];
            end
            if (e[9]) begin
                ib = e[7:0];
                pb = e[12];
                nb = e[7:0];
                npb = e[12];
            end
        end else begin
            up = e[11] && !e[12];
        end
        if (up && e[10] && e[16]) begin
            ep = 1'b1;
            up = 1'b0;
        end
        if (up) begin
            ca = ia;
            cb = ib;
        end
        // no strobe: load bit alone decides, always at select rise
        if (e[11]) begin
            nca = na;
            ncb = nb;
        end
        host_u.strobe(e[16]);
        host_u.send(e[15:0]);
        for (int i = 0; i < 12 && !seen; i++) begin
            @(negedge i_clock);
            seen = (cmd_stb === 1'b1) && (n_stb === 1'b1);
        end
        @(negedge i_clock);
        chk("cmd_strobe", {7'h00, seen}, 8'h01);
        chk_all();
    endtask : cmd

    // strobe fall; with nothing pending it must change nothing
    task automatic fall();
        host_u.strobe(1'b0);
        repeat (8) @(negedge i_clock);
        if (ep) begin
            ca = ia;
            cb = ib;
            ep = 1'b0;
        end
        chk_all();
        host_u.strobe(1'b1);
    endtask : fall

    task automatic complete_run();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        i_rst_b = 1'b0;
        repeat (20) @(posedge i_clock);
        @(negedge i_clock) i_rst_b = 1'b1;
        @(negedge i_clock);
        chk_all();
        fall();
        foreach (plan[i]) begin
            cmd(plan[i]);
            if (ep) fall();
        end
        complete_run();
    end

    initial begin
        #100000;
        fails++;
        complete_run();
    end
endmodule : tb_top
